// ### rtl/ssc_frame_ctrl.sv
/*
 * ssc_frame_ctrl: receives secure session control frames byte by byte, checks them,
 * decodes the session request and keeps the client timer and the incoming slot table.
 * assumes bytes come from logic on pclk (no synchroniser) and an apb master for registers.
 */
// The APB register port and the address map were left to the implementer.
module ssc_frame_ctrl
  import ssc_pkg::*;
#(
  parameter int TICK_CYCLES = SSC_TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial api byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // decoded actions
  output ssc_act_t act,
  output logic act_discard,
  // client session timer
  input wire logic secure_tx,
  output logic client_active,
  output logic client_expired,
  // incoming session requests from the radio side
  input wire logic srv_req_valid,
  input wire logic [63:0] srv_req_peer,
  input wire logic [15:0] srv_req_timeout,
  output logic srv_accept,
  output logic srv_evict,
  output logic srv_refuse
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // parser state
  ssc_state_t state;
  logic [15:0] len;
  logic [15:0] rem;
  logic [15:0] pos;
  logic [7:0] sum;
  logic [7:0] ftype;
  logic [63:0] dest;
  logic [7:0] opt;
  logic [15:0] tmo;
  logic [6:0] pw_len;
  logic too_long;
  logic [7:0] pw_mem [SSC_MAX_PW];
  logic ctrl_en;
  logic [15:0] csum_errs;
  logic [15:0] len_errs;
  logic [3:0] last_status;
  logic [SSC_NSLOT-1:0] slot_valid;
  logic [SSC_NSLOT-1:0] slot_yield;
  logic [63:0] slot_peer [SSC_NSLOT];
  logic [7:0] slot_age [SSC_NSLOT];

  wire logic byte_in = rx_valid && ctrl_en;
  wire logic frame_done = byte_in && (state == SSC_CSUM);
  wire logic [7:0] next_sum = sum + rx_data;
  wire logic csum_ok = (next_sum == SSC_CSUM_GOOD);
  wire logic type_ok = (ftype == SSC_TYPE);
  wire logic is_logout = opt[SSC_OPT_LOGOUT];
  wire logic is_term = !opt[SSC_OPT_LOGOUT] && opt[SSC_OPT_TERM];
  wire logic is_bcast = (dest == SSC_BCAST);
  wire logic len_short = (len < SSC_MIN_LEN_CTRL) ||
                         (!is_logout && !is_term && (len < SSC_MIN_LEN_LOGIN));
  wire logic pw_over = too_long && !is_logout && !is_term;
  wire logic frame_bad = !csum_ok || len_short || pw_over;
  wire logic frame_go = frame_done && type_ok && !frame_bad;

  ////////////////////////////////////////////////////////////////////////////
  // frame state machine: delimiter, length, body, checksum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SSC_IDLE;
      len <= 16'h0000;
      rem <= 16'h0000;
    end else if (byte_in) begin
      unique case (state)
        SSC_IDLE: begin
          if (rx_data == SSC_START) begin
            state <= SSC_LEN_HI;
          end
        end
        SSC_LEN_HI: begin
          len <= {rx_data, 8'h00};
          state <= SSC_LEN_LO;
        end
        SSC_LEN_LO: begin
          len <= {len[15:8], rx_data};
          rem <= {len[15:8], rx_data};
          state <= ({len[15:8], rx_data} == 16'h0000) ? SSC_CSUM : SSC_BODY;
        end
        SSC_BODY: begin
          rem <= rem - 16'h0001;
          if (rem == 16'h0001) begin
            state <= SSC_CSUM;
          end
        end
        SSC_CSUM: begin
          state <= SSC_IDLE;
        end
      endcase
    end
  end

  // byte position and running sum over the body
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 16'h0000;
      sum <= 8'h00;
    end else if (byte_in && state == SSC_LEN_LO) begin
      pos <= SSC_OFS_TYPE;
      sum <= 8'h00;
    end else if (byte_in && state == SSC_BODY) begin
      pos <= pos + 16'h0001;
      sum <= next_sum;
    end
  end

  // field capture by position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ftype <= 8'h00;
      dest <= 64'h0000_0000_0000_0000;
      opt <= 8'h00;
      tmo <= 16'h0000;
      pw_len <= 7'h00;
      too_long <= 1'b0;
    end else if (byte_in && state == SSC_LEN_LO) begin
      ftype <= 8'h00;
      opt <= 8'h00;
      tmo <= 16'h0000;
      pw_len <= 7'h00;
      too_long <= 1'b0;
    end else if (byte_in && state == SSC_BODY) begin
      if (pos == SSC_OFS_TYPE) begin
        ftype <= rx_data;
      end else if (pos >= SSC_OFS_DEST && pos <= SSC_OFS_DEST_END) begin
        dest <= {dest[55:0], rx_data};
      end else if (pos == SSC_OFS_OPT) begin
        opt <= rx_data;
      end else if (pos == SSC_OFS_TMO_HI) begin
        tmo <= {rx_data, tmo[7:0]};
      end else if (pos == SSC_OFS_TMO_LO) begin
        tmo <= {tmo[15:8], rx_data};
      end else if (pw_len < SSC_MAX_PW) begin
        pw_len <= pw_len + 7'h01;
      end else begin
        too_long <= 1'b1;
      end
    end
  end

  // password store, no reset needed for data
  always_ff @(posedge pclk) begin
    if (byte_in && state == SSC_BODY && pos >= SSC_OFS_PW && pw_len < SSC_MAX_PW) begin
      pw_mem[pw_len[5:0]] <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode into one action pulse at the checksum byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= '0;
      act_discard <= 1'b0;
      last_status <= SSC_STAT_OK;
    end else begin
      act <= '0;
      act_discard <= frame_done && type_ok && frame_bad;
      if (frame_go) begin
        act.dest <= dest;
        act.broadcast <= is_bcast;
        if (is_logout) begin
          act.logout <= 1'b1;
        end else if (is_term) begin
          act.terminate <= 1'b1;
        end else if (is_bcast || tmo > SSC_MAX_TMO) begin
          act.reject <= 1'b1;
          act.status <= SSC_STAT_INVALID;
          last_status <= SSC_STAT_INVALID;
        end else begin
          act.login <= 1'b1;
          act.timeout <= tmo;
          act.interpkt <= opt[SSC_OPT_IPT];
          last_status <= SSC_STAT_OK;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tenth of a second tick
  logic [23:0] tick_cnt;
  wire logic tick = (tick_cnt == 24'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
    end
  end

  // client session timer
  logic [15:0] cli_tmo;
  logic [15:0] cli_left;
  logic cli_ipt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      client_active <= 1'b0;
      client_expired <= 1'b0;
      cli_tmo <= 16'h0000;
      cli_left <= 16'h0000;
      cli_ipt <= 1'b0;
    end else begin
      client_expired <= 1'b0;
      if (act.login) begin
        client_active <= 1'b1;
        cli_tmo <= act.timeout;
        cli_left <= act.timeout;
        cli_ipt <= act.interpkt;
      end else if (act.logout) begin
        client_active <= 1'b0;
      end else if (client_active && cli_ipt && secure_tx) begin
        cli_left <= cli_tmo;
      end else if (client_active && tick && cli_tmo != 16'h0000) begin
        cli_left <= cli_left - 16'h0001;
        if (cli_left == 16'h0001) begin
          client_active <= 1'b0;
          client_expired <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // incoming session slots
  function automatic logic [2:0] find_free(input logic [SSC_NSLOT-1:0] v);
    logic [2:0] r;
    r = 3'b000;
    for (int i = SSC_NSLOT - 1; i >= 0; i--) begin
      if (!v[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  logic old_hit;
  logic [1:0] old_idx;

  // oldest yielding slot, non-zero timeout slots are never candidates
  always_comb begin
    logic [7:0] best;
    best = 8'h00;
    old_hit = 1'b0;
    old_idx = 2'b00;
    for (int i = 0; i < SSC_NSLOT; i++) begin
      if (slot_valid[i] && slot_yield[i] && (!old_hit || slot_age[i] > best)) begin
        old_hit = 1'b1;
        old_idx = 2'(i);
        best = slot_age[i];
      end
    end
  end

  wire logic [2:0] free_slot = find_free(slot_valid);
  wire logic ins_go = srv_req_valid && (free_slot[2] || old_hit);
  wire logic [1:0] ins_idx = free_slot[2] ? free_slot[1:0] : old_idx;

  generate
    for (genvar s = 0; s < SSC_NSLOT; s++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_valid[s] <= 1'b0;
          slot_yield[s] <= 1'b0;
          slot_peer[s] <= 64'h0000_0000_0000_0000;
          slot_age[s] <= 8'h00;
        end else if (ins_go && ins_idx == 2'(s)) begin
          slot_valid[s] <= 1'b1;
          slot_yield[s] <= (srv_req_timeout == 16'h0000);
          slot_peer[s] <= srv_req_peer;
          slot_age[s] <= 8'h00;
        end else if (act.terminate && slot_valid[s] && (act.broadcast || slot_peer[s] == act.dest)) begin
          slot_valid[s] <= 1'b0;
        end else if (ins_go && slot_valid[s] && slot_age[s] != 8'hff) begin
          slot_age[s] <= slot_age[s] + 8'h01;
        end
      end
    end
  endgenerate

  // request answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srv_accept <= 1'b0;
      srv_evict <= 1'b0;
      srv_refuse <= 1'b0;
    end else begin
      srv_accept <= ins_go;
      srv_evict <= ins_go && !free_slot[2];
      srv_refuse <= srv_req_valid && !ins_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: answer on the second access cycle
  wire logic apb_take = psel && penable && !pready;
  wire logic apb_fire = psel && penable && pready;
  wire logic clr_cnt = apb_fire && pwrite && paddr == SSC_REG_CTRL && pstrb[0] && pwdata[SSC_CTRL_CLR];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en <= SSC_CTRL_EN_RST;
    end else if (apb_fire && pwrite && paddr == SSC_REG_CTRL && pstrb[0]) begin
      ctrl_en <= pwdata[SSC_CTRL_EN];
    end
  end

  // error counters, a new error wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csum_errs <= 16'h0000;
      len_errs <= 16'h0000;
    end else begin
      if (frame_done && type_ok && !csum_ok) begin
        csum_errs <= clr_cnt ? 16'h0001 : csum_errs + 16'h0001;
      end else if (clr_cnt) begin
        csum_errs <= 16'h0000;
      end
      if (frame_done && type_ok && csum_ok && (len_short || pw_over)) begin
        len_errs <= clr_cnt ? 16'h0001 : len_errs + 16'h0001;
      end else if (clr_cnt) begin
        len_errs <= 16'h0000;
      end
    end
  end

  // read mux
  logic [31:0] next_prdata;
  logic next_err;
  always_comb begin
    logic [5:0] w;
    w = {paddr[5:2], 2'b00};
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr >= SSC_REG_PW_BASE && paddr <= SSC_REG_PW_LAST && paddr[1:0] == 2'b00) begin
      next_prdata = {pw_mem[w + 6'h03], pw_mem[w + 6'h02], pw_mem[w + 6'h01], pw_mem[w]};
    end else begin
      unique case (paddr)
        SSC_REG_CTRL: next_prdata = {31'h0000_0000, ctrl_en};
        SSC_REG_STATUS: next_prdata = {16'h0000, slot_yield, slot_valid, last_status, 2'b00, cli_ipt, client_active};
        SSC_REG_DEST_LO: next_prdata = dest[31:0];
        SSC_REG_DEST_HI: next_prdata = dest[63:32];
        SSC_REG_OPT_TMO: next_prdata = {tmo, 8'h00, opt};
        SSC_REG_PW_LEN: next_prdata = {25'h000_0000, pw_len};
        SSC_REG_ERRCNT: next_prdata = {len_errs, csum_errs};
        default: next_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_take;
      prdata <= (apb_take && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= apb_take && next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  resync_start_a: assert property ((state == SSC_IDLE && byte_in && rx_data == SSC_START)
    |=> state == SSC_LEN_HI) else $error("delimiter did not start a frame");
  len_count_a: assert property (frame_done |-> pos == len + SSC_OFS_TYPE)
    else $error("length count wrong");
  type_route_a: assert property ((frame_done && !type_ok) |=> !act.login && !act.logout && !act.terminate
    && !act.reject) else $error("foreign frame type acted on");
  csum_drop_a: assert property ((frame_done && !csum_ok) |=> act == '0 ##1 !act.login)
    else $error("bad checksum frame acted on");
  short_drop_a: assert property ((frame_done && type_ok && len < SSC_MIN_LEN_CTRL) |=> act_discard && !act.logout)
    else $error("short frame not discarded");
  logout_only_a: assert property (act.logout |-> !act.login && !act.terminate && act.timeout == 16'h0000)
    else $error("logout carried other actions");
  bcast_login_a: assert property ((frame_go && !is_logout && !is_term && is_bcast)
    |=> act.reject && act.status == SSC_STAT_INVALID) else $error("broadcast login not refused");
  tmo_limit_a: assert property (act.login |-> act.timeout <= SSC_MAX_TMO) else $error("timeout over limit");
  yield_hold_a: assert property ((client_active && cli_tmo == 16'h0000 && !act.logout && !act.login)
    |=> client_active) else $error("yielding session expired");
  evict_yield_a: assert property ((srv_req_valid && !free_slot[2] && ins_go) |-> slot_yield[ins_idx])
    else $error("timed session evicted");
  ipt_reload_a: assert property ((client_active && cli_ipt && secure_tx && !act.login && !act.logout)
    |=> cli_left == $past(cli_tmo)) else $error("inter-packet timer not restarted");

endmodule

// ### rtl/ssc_pkg.sv
/*
 * ssc_pkg: constants and carrier types for the secure session control frame decoder.
 * assumes a 100 MHz pclk and 32-bit apb data with one aligned word per register.
 */
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam logic [7:0] SSC_START = 8'h7e;          // start delimiter byte
  localparam logic [7:0] SSC_TYPE = 8'h2e;           // session control frame type
  localparam logic [15:0] SSC_OFS_TYPE = 16'h0003;
  localparam logic [15:0] SSC_OFS_DEST = 16'h0004;
  localparam logic [15:0] SSC_OFS_DEST_END = 16'h000b;
  localparam logic [15:0] SSC_OFS_OPT = 16'h000c;
  localparam logic [15:0] SSC_OFS_TMO_HI = 16'h000d;
  localparam logic [15:0] SSC_OFS_TMO_LO = 16'h000e;
  localparam logic [15:0] SSC_OFS_PW = 16'h000f;
  localparam logic [15:0] SSC_MIN_LEN_CTRL = 16'h000a;   // type, address, options
  localparam logic [15:0] SSC_MIN_LEN_LOGIN = 16'h000c;  // plus timeout
  localparam logic [6:0] SSC_MAX_PW = 7'h40;
  localparam logic [7:0] SSC_CSUM_GOOD = 8'hff;
  localparam int SSC_OPT_LOGOUT = 0;
  localparam int SSC_OPT_TERM = 1;
  localparam int SSC_OPT_IPT = 2;
  localparam logic [15:0] SSC_MAX_TMO = 16'h4650;
  localparam logic [63:0] SSC_BCAST = 64'h0000_0000_0000_ffff;
  localparam logic [3:0] SSC_STAT_OK = 4'h0;
  localparam logic [3:0] SSC_STAT_INVALID = 4'ha;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SSC_CLK_NS = 10;
  localparam int SSC_TENTH_NS = 100000000;
  localparam int SSC_TICK_CYCLES = SSC_TENTH_NS / SSC_CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // incoming session slots
  localparam int SSC_NSLOT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register map and fields
  localparam logic [11:0] SSC_REG_CTRL = 12'h000;
  localparam logic [11:0] SSC_REG_STATUS = 12'h004;
  localparam logic [11:0] SSC_REG_DEST_LO = 12'h008;
  localparam logic [11:0] SSC_REG_DEST_HI = 12'h00c;
  localparam logic [11:0] SSC_REG_OPT_TMO = 12'h010;
  localparam logic [11:0] SSC_REG_PW_LEN = 12'h014;
  localparam logic [11:0] SSC_REG_ERRCNT = 12'h018;
  localparam logic [11:0] SSC_REG_PW_BASE = 12'h100;
  localparam logic [11:0] SSC_REG_PW_LAST = 12'h13c;
  localparam int SSC_CTRL_EN = 0;
  localparam int SSC_CTRL_CLR = 1;
  localparam logic SSC_CTRL_EN_RST = 1'b1;

  // one decoded action towards the session logic
  typedef struct packed {
    logic login;
    logic logout;
    logic terminate;
    logic reject;
    logic broadcast;
    logic interpkt;
    logic [3:0] status;
    logic [15:0] timeout;
    logic [63:0] dest;
  } ssc_act_t;

  typedef enum logic [4:0] {
    SSC_IDLE = 5'b00001,
    SSC_LEN_HI = 5'b00010,
    SSC_LEN_LO = 5'b00100,
    SSC_BODY = 5'b01000,
    SSC_CSUM = 5'b10000
  } ssc_state_t;

endpackage

// ### testbench/secure_session_control_frame_bench.sv
/*
 * secure_session_control_frame_bench: random and corner frames, apb reads, slot and timer checks.
 * assumes ssc_host_model drives the byte stream and TICK_CYCLES is 4.
 */
module secure_session_control_frame_bench import ssc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic secure_tx = 1'b0;
  logic srv_req_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [63:0] srv_req_peer = 64'h0;
  logic [15:0] srv_req_timeout = 16'h0;
  logic [31:0] prdata;
  logic [7:0] rx_data;
  logic pready, pslverr, rx_valid, act_discard, client_active, client_expired, srv_accept, srv_evict, srv_refuse;
  ssc_act_t act, got;
  int bad_count = 0;
  int samples_checked = 0;
  int got_n = 0;
  int disc_n = 0;
  int exp_n = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 pclk = ~pclk;

  ssc_frame_ctrl #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .act(act), .act_discard(act_discard),
    .secure_tx(secure_tx), .client_active(client_active), .client_expired(client_expired),
    .srv_req_valid(srv_req_valid), .srv_req_peer(srv_req_peer), .srv_req_timeout(srv_req_timeout),
    .srv_accept(srv_accept), .srv_evict(srv_evict), .srv_refuse(srv_refuse));
  ssc_host_model host (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data));

  // catch one-cycle pulses and cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (act.login | act.logout | act.terminate | act.reject) begin
      got <= act;
      got_n <= got_n + 1;
    end
    if (act_discard) disc_n <= disc_n + 1;
    if (client_expired) exp_n <= exp_n + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // apb read or write, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] kind(input ssc_act_t a);
    return {a.login, a.logout, a.terminate, a.reject, a.status};
  endfunction

  // decision order: logout, terminate, refusal, login
  function automatic ssc_act_t expect_act(input logic [63:0] d, input logic [7:0] o, input logic [15:0] t);
    ssc_act_t a;
    a = '0;
    a.dest = d;
    a.timeout = t;
    a.interpkt = o[SSC_OPT_IPT];
    a.broadcast = (d == SSC_BCAST);
    if (o[SSC_OPT_LOGOUT]) a.logout = 1'b1;
    else if (o[SSC_OPT_TERM]) a.terminate = 1'b1;
    else if (a.broadcast || t > SSC_MAX_TMO) begin
      a.reject = 1'b1;
      a.status = SSC_STAT_INVALID;
    end else a.login = 1'b1;
    return a;
  endfunction

  // mode 0 expects an action, 1 a discard, 2 nothing
  task automatic req(input logic [7:0] typ, input logic [63:0] d, input logic [7:0] o, input logic [15:0] t,
                     input int npw, input int keep, input logic bad, input int mode);
    logic [7:0] q[$];
    int n0;
    int d0;
    ssc_act_t e;
    q.push_back(typ);
    for (int i = 7; i >= 0; i--) q.push_back(d[i*8+:8]);
    q.push_back(o);
    q.push_back(t[15:8]);
    q.push_back(t[7:0]);
    repeat (npw) q.push_back(8'h21 + 8'($urandom % 94));
    while (q.size() > keep) void'(q.pop_back());
    n0 = got_n;
    d0 = disc_n;
    e = expect_act(d, o, t);
    host.send(q, $urandom % 3, bad);
    repeat (4) @(posedge pclk);
    chk("action count", n0 + (mode == 0), got_n);
    chk("discard count", d0 + (mode == 1), disc_n);
    if (mode == 0) chk("action kind", kind(e), kind(got));
    if (mode == 0 && e.login) chk("login dest", e.dest, got.dest);
    if (mode == 0 && e.login) chk("login timing", {e.timeout, e.interpkt}, {got.timeout, got.interpkt});
    if (mode == 0 && e.terminate) chk("broadcast", e.broadcast, got.broadcast);
  endtask

  // one incoming session request; answer is {accept, evict, refuse}
  task automatic srv(input logic [63:0] p, input logic [15:0] t, input logic [2:0] e);
    @(posedge pclk);
    srv_req_valid <= 1'b1;
    srv_req_peer <= p;
    srv_req_timeout <= t;
    @(posedge pclk);
    srv_req_valid <= 1'b0;
    #1 chk("server answer", e, {srv_accept, srv_evict, srv_refuse});
  endtask

  // cycles until the next expiry pulse, capped at lim
  task automatic wait_exp(input int lim, output int n);
    int e0;
    e0 = exp_n;
    n = 0;
    while (exp_n == e0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    int n;
    logic [63:0] d;
    void'($urandom(17));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SSC_REG_CTRL, 32'h0, r, e);
    chk("ctrl reset", SSC_CTRL_EN_RST, r[0]);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped", 33'h0, {e ^ 1'b1, r});
    repeat (8) begin
      d = {$urandom, $urandom};
      req(SSC_TYPE, d, 8'($urandom & 32'h4), 16'($urandom % 32'h4651), $urandom % 65, 99, 0, 0);
    end
    apb(1'b0, SSC_REG_DEST_LO, 32'h0, r, e);
    chk("dest low reg", d[31:0], r);
    req(SSC_TYPE, d, 8'h07, 16'hffff, 5, 99, 0, 0);
    chk("logout ends client", 1'b0, client_active);
    req(SSC_TYPE, SSC_BCAST, 8'h06, 16'h0000, 3, 99, 0, 0);
    req(SSC_TYPE, SSC_BCAST, 8'h00, 16'h0010, 4, 99, 0, 0);
    req(SSC_TYPE, d, 8'h00, 16'h4651, 4, 99, 0, 0);
    req(SSC_TYPE, d, 8'h04, 16'h4650, 64, 99, 0, 0);
    req(SSC_TYPE, d, 8'h00, 16'h0020, 2, 99, 1, 1);
    req(SSC_TYPE, d, 8'h00, 16'h0020, 0, 9, 0, 1);
    apb(1'b0, SSC_REG_ERRCNT, 32'h0, r, e);
    chk("error counts", 32'h0001_0001, r);
    req(SSC_TYPE, d, 8'h00, 16'h0020, 65, 99, 0, 1);
    req(SSC_TYPE, d, 8'h01, 16'h0000, 65, 99, 0, 0);
    req(8'h2d, d, 8'h00, 16'h0020, 2, 99, 0, 2);
    apb(1'b1, SSC_REG_CTRL, 32'h0, r, e);
    req(SSC_TYPE, d, 8'h00, 16'h0020, 2, 99, 0, 2);
    apb(1'b1, SSC_REG_CTRL, 32'h1, r, e);
    // fill the four slots with timed sessions, then with two timed and two yielding ones
    for (int i = 1; i <= 4; i++) srv(64'(i), 16'h0100, 3'b100);
    srv(64'h5, 16'h0100, 3'b001);
    req(SSC_TYPE, SSC_BCAST, 8'h02, 16'h0000, 0, 99, 0, 0);
    srv(64'h1, 16'h0005, 3'b100);
    srv(64'h2, 16'h0000, 3'b100);
    srv(64'h3, 16'h0000, 3'b100);
    srv(64'h4, 16'h0007, 3'b100);
    srv(64'h5, 16'h0009, 3'b110);
    apb(1'b0, SSC_REG_STATUS, 32'h0, r, e);
    chk("slot table", 8'h4f, r[15:8]);
    req(SSC_TYPE, 64'h3, 8'h02, 16'h0000, 0, 99, 0, 0);
    apb(1'b0, SSC_REG_STATUS, 32'h0, r, e);
    chk("slot after terminate", 4'hb, r[11:8]);
    // client timer: fixed, refreshed, yielding
    req(SSC_TYPE, d, 8'h00, 16'h0003, 1, 99, 0, 0);
    wait_exp(60, n);
    chk("fixed expiry", 1, n >= 4 && n <= 16);
    chk("expired client", 1'b0, client_active);
    req(SSC_TYPE, d, 8'h04, 16'h0003, 1, 99, 0, 0);
    n = exp_n;
    repeat (6) begin
      repeat (2) @(posedge pclk);
      secure_tx <= 1'b1;
      @(posedge pclk);
      secure_tx <= 1'b0;
    end
    chk("refreshed timer", n, exp_n);
    wait_exp(60, n);
    chk("silent expiry", 1, n < 30);
    req(SSC_TYPE, d, 8'h00, 16'h0000, 1, 99, 0, 0);
    wait_exp(60, n);
    chk("yielding no expiry", 60, n);
    chk("yielding client", 1'b1, client_active);
    tally_and_finish();
  end
endmodule

// ### testbench/ssc_host_model.sv
/*
 * ssc_host_model: host processor that sends api frames byte by byte.
 * assumes the bench calls send() from a single process, on pclk.
 */
module ssc_host_model (
  // clock
  input wire logic pclk,
  // byte stream towards the decoder
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0;
  logic [7:0] cur = 8'h00;
  logic [7:0] pat = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // idle data lines wander so a stale byte is never mistaken for a new one
  initial rx_valid = 1'b0;
  always @(posedge pclk) pat <= pat + 8'h35;
  assign rx_data = busy ? cur : pat;

  // one byte, then an optional gap with the strobe low
  task automatic put(input logic [7:0] b, input int gap);
    @(posedge pclk);
    busy <= 1'b1;
    cur <= b;
    rx_valid <= 1'b1;
    repeat (gap) begin
      @(posedge pclk);
      rx_valid <= 1'b0;
    end
  endtask

  // whole frame: delimiter, length, body, checksum (bad flips bit 0)
  task automatic send(input logic [7:0] body[$], input int gap, input logic bad);
    logic [7:0] s;
    int n;
    s = 8'h00;
    n = body.size();
    put(8'h7e, gap);
    put(n[15:8], gap);
    put(n[7:0], gap);
    foreach (body[i]) begin
      put(body[i], gap);
      s = s + body[i];
    end
    put((8'hff - s) ^ {7'h00, bad}, gap);
    @(posedge pclk);
    rx_valid <= 1'b0;
    busy <= 1'b0;
  endtask
endmodule
